// ===== dv/dio_edge_status_monitor.sv
module dio_edge_status_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [19:0] line_in,
  input wire logic [19:0] line_edge_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [119:0] d;
  logic [19:0] chg;
  logic st;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  assign st = wb_adr_i[11:2] == 10'h0E3;
  always_ff @(posedge clk) d <= {d[99:0], line_in};
  always_comb begin
    chg = 20'h00000;
    for (int i = 0; i < 5; i++) chg |= d[i*20 +: 20] ^ d[i*20+20 +: 20];
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  read_value_a: assert property (wb_ack_o && !wb_we_i && st |->
    wb_dat_o == {12'h000, $past(line_edge_flag)}) else $error("status read wrong");
  edge_cause_a: assert property ((line_edge_flag & ~$past(line_edge_flag) & ~chg) == 0)
    else $error("flag set without edge");
  flag_sticky_a: assert property (|($past(line_edge_flag) & ~line_edge_flag) |->
    wb_ack_o && st) else $error("flag lost");
  w1c_only_a: assert property (wb_ack_o && wb_we_i && st |->
    ($past(line_edge_flag) & ~line_edge_flag & ~wb_dat_i[19:0]) == 0) else $error("bad clear");
  cover property (wb_ack_o && st && !wb_we_i && |wb_dat_o);
  cover property (|(line_edge_flag & ~$past(line_edge_flag)));
  cover property (wb_ack_o && wb_we_i && st && |$past(line_edge_flag));
  cover property (wb_ack_o && wb_we_i && st &&
    |($past(line_edge_flag) & line_edge_flag & wb_dat_i[19:0]));
endmodule // dio_edge_status_monitor
bind dio_edge_interrupt_status dio_edge_status_monitor mon_u (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_in(line_in),
  .line_edge_flag(line_edge_flag));

// ===== dv/dio_line_source.sv
module dio_line_source (
  input wire logic clk,
  input wire logic [19:0] flip,
  output logic [19:0] line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_in = 20'h00000;
  // lines change only on command, so levels stand long enough to be synced
  always @(posedge clk) line_in <= line_in ^ flip;
endmodule // dio_line_source

// ===== dv/test_dio_edge_interrupt_status.sv
module test_dio_edge_interrupt_status;
  timeunit 1ns;
  timeprecision 1ns;
  import dio_edge_pkg::*;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h00000000, rd, dat_o;
  logic [19:0] line, flags, flip = 20'h00000, lv = 20'h00000, exp = 20'h00000, ren, fen, t;
  int num_errors = 0, total_checks = 0, cycles = 0, seed = 26279;
  initial forever #10 clk = ~clk;
  dio_edge_interrupt_status dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .line_in(line), .line_edge_flag(flags));
  dio_line_source src_u (.clk(clk), .flip(flip), .line_in(line));
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0; stb <= 0;
  endtask
  task automatic tog(input logic [19:0] v);
    @(posedge clk) flip <= v;
    @(posedge clk) flip <= 20'h00000;
    repeat (8) @(posedge clk);
    exp |= (v & ~lv & ren) | (v & lv & fen);
    lv ^= v;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    ren = 0; fen = 0;
    acc(0, 12'h000, 0); `CHK(rd, 32'h00000000)
    tog(20'hFFFFF);
    acc(0, STATUS_OFS, 0); `CHK(rd, 32'h00000000)
    for (int m = 0; m < 2; m++) begin
      acc(1, GLOBAL_CFG_OFS, 32'(m * 2));
      acc(0, GLOBAL_CFG_OFS, 0); `CHK(rd, 32'(m * 2))
      for (int i = 0; i < 6; i++) begin
        ren = (i == 0) ? 20'hFFFFF : 20'($random(seed));
        fen = (i == 0) ? 20'hFFFFF : 20'($random(seed));
        acc(1, RISE_EN_OFS, {12'h000, ren});
        acc(1, FALL_EN_OFS, {12'h000, fen});
        tog(20'($random(seed)));
        tog(20'($random(seed)));
        acc(0, STATUS_OFS, 0); `CHK(rd, {12'h000, exp})
        if (m == 1) exp = 0;
        t = 20'($random(seed));
        acc(1, STATUS_OFS, {12'h000, t});
        if (m == 0) exp &= ~t;
        acc(0, STATUS_OFS, 0); `CHK(rd, {12'h000, exp})
        if (m == 1) exp = 0;
      end
    end
    // corners: byte-gated clear, then a clear landing on the same edge as a new event
    acc(1, GLOBAL_CFG_OFS, 0);
    ren = 20'hFFFFF;
    fen = 20'hFFFFF;
    acc(1, RISE_EN_OFS, {12'h000, ren});
    acc(0, RISE_EN_OFS, 0); `CHK(rd, {12'h000, ren})
    acc(1, FALL_EN_OFS, {12'h000, fen});
    acc(1, STATUS_OFS, 32'h000FFFFF);
    exp = 20'h00000;
    tog(20'h00101);
    sel <= 4'h1;
    acc(1, STATUS_OFS, 32'h00000101);
    sel <= 4'hF;
    exp &= ~20'h00001;
    acc(0, STATUS_OFS, 0); `CHK(rd, {12'h000, exp})
    // line toggles at the second edge; its set lands on the take edge of the clear
    @(posedge clk) flip <= 20'h00100;
    @(posedge clk) flip <= 20'h00000;
    @(posedge clk);
    acc(1, STATUS_OFS, 32'h00000100);
    lv ^= 20'h00100;
    acc(0, STATUS_OFS, 0); `CHK(rd, {12'h000, exp})
    `CHK(flags, exp)
    acc(0, LINE_LEVEL_OFS, 0); `CHK(rd, {12'h000, lv})
    give_verdict;
  end
endmodule // test_dio_edge_interrupt_status

// ===== logic/dio_edge_interrupt_status.sv
module dio_edge_interrupt_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dio_edge_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [dio_edge_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [dio_edge_pkg::DATA_W-1:0] wb_dat_i,
  output logic [dio_edge_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [dio_edge_pkg::LINE_COUNT-1:0] line_in,
  output logic [dio_edge_pkg::LINE_COUNT-1:0] line_edge_flag
);
  import dio_edge_pkg::*;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
    logic [LINE_COUNT-1:0] rise_en;
    logic [LINE_COUNT-1:0] fall_en;
    logic ack_mode;
  } regs_t;

  regs_t r_r;
  regs_t r_nxt;
  logic [LINE_COUNT-1:0] level;
  logic [LINE_COUNT-1:0] rise;
  logic [LINE_COUNT-1:0] fall;
  logic [LINE_COUNT-1:0] clr;
  logic [DATA_W-1:0] wmask;
  logic take;

  line_edge_sampler #(
    .WIDTH(LINE_COUNT)
  ) sampler (
    .clk(clk),
    .rst(rst),
    .line_in(line_in),
    .level(level),
    .rise(rise),
    .fall(fall)
  );

  edge_flag_bank #(
    .WIDTH(LINE_COUNT)
  ) bank (
    .clk(clk),
    .rst(rst),
    .rise(rise),
    .fall(fall),
    .rise_en(r_r.rise_en),
    .fall_en(r_r.fall_en),
    .clr(clr),
    .flags(line_edge_flag)
  );

  // one request per ack; ack low in the cycle after it was high
  assign take = wb_cyc_i && wb_stb_i && !r_r.ack;
  assign wmask = lane_mask(wb_sel_i);

  always_comb begin
    clr = '0;
    if (take && word_hit(wb_adr_i, STATUS_OFS)) begin
      if (wb_we_i && !r_r.ack_mode) begin
        clr = wb_dat_i[LINE_COUNT-1:0] & wmask[LINE_COUNT-1:0];
      end else if (!wb_we_i && r_r.ack_mode) begin
        // only bits the reader sees are dropped
        clr = line_edge_flag;
      end
    end
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.ack = take;
    if (take) begin
      r_nxt.dat = DATA_RESET;
      if (!wb_we_i) begin
        if (word_hit(wb_adr_i, STATUS_OFS)) begin
          r_nxt.dat[LINE_COUNT-1:0] = line_edge_flag;
        end else if (word_hit(wb_adr_i, RISE_EN_OFS)) begin
          r_nxt.dat[LINE_COUNT-1:0] = r_r.rise_en;
        end else if (word_hit(wb_adr_i, FALL_EN_OFS)) begin
          r_nxt.dat[LINE_COUNT-1:0] = r_r.fall_en;
        end else if (word_hit(wb_adr_i, GLOBAL_CFG_OFS)) begin
          r_nxt.dat[ACK_MODE_POS] = r_r.ack_mode;
        end else if (word_hit(wb_adr_i, LINE_LEVEL_OFS)) begin
          r_nxt.dat[LINE_COUNT-1:0] = level;
        end
      end else begin
        if (word_hit(wb_adr_i, RISE_EN_OFS)) begin
          r_nxt.rise_en = lane_merge(r_r.rise_en, wb_dat_i, wb_sel_i);
        end else if (word_hit(wb_adr_i, FALL_EN_OFS)) begin
          r_nxt.fall_en = lane_merge(r_r.fall_en, wb_dat_i, wb_sel_i);
        end else if (word_hit(wb_adr_i, GLOBAL_CFG_OFS) && wb_sel_i[0]) begin
          r_nxt.ack_mode = wb_dat_i[ACK_MODE_POS];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r.ack <= 1'b0;
      r_r.dat <= DATA_RESET;
      r_r.rise_en <= EN_RESET;
      r_r.fall_en <= EN_RESET;
      r_r.ack_mode <= ACK_MODE_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign wb_ack_o = r_r.ack;
  assign wb_dat_o = r_r.dat;

endmodule // dio_edge_interrupt_status

// ===== logic/dio_edge_pkg.sv
package dio_edge_pkg;

  localparam int LINE_COUNT = 20;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;

  // byte addresses on the bus
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h38C;
  localparam logic [ADDR_W-1:0] RISE_EN_OFS = 12'h390;
  localparam logic [ADDR_W-1:0] FALL_EN_OFS = 12'h394;
  localparam logic [ADDR_W-1:0] GLOBAL_CFG_OFS = 12'h398;
  localparam logic [ADDR_W-1:0] LINE_LEVEL_OFS = 12'h3B0;

  localparam int ACK_MODE_POS = 1;
  localparam logic ACK_MODE_RESET = 1'b0;
  localparam logic [LINE_COUNT-1:0] STATUS_RESET = 20'h00000;
  localparam logic [LINE_COUNT-1:0] EN_RESET = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

  // cycles after reset before the sampler trusts its history
  // meta, stable and prev must all hold real samples, else a line high at reset looks like a rise
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
    logic [DATA_W-1:0] m;
    m = DATA_RESET;
    for (int i = 0; i < SEL_W; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  function automatic logic [LINE_COUNT-1:0] lane_merge(
    input logic [LINE_COUNT-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [SEL_W-1:0] sel
  );
    logic [DATA_W-1:0] m;
    m = lane_mask(sel);
    return (old_val & ~m[LINE_COUNT-1:0]) | (wdata[LINE_COUNT-1:0] & m[LINE_COUNT-1:0]);
  endfunction

  function automatic logic word_hit(
    input logic [ADDR_W-1:0] adr,
    input logic [ADDR_W-1:0] ofs
  );
    return adr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

endpackage

// ===== logic/edge_flag_bank.sv
module edge_flag_bank #(
  parameter int WIDTH = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] rise,
  input wire logic [WIDTH-1:0] fall,
  input wire logic [WIDTH-1:0] rise_en,
  input wire logic [WIDTH-1:0] fall_en,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);
  import dio_edge_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_t;

  bank_t b_r;
  bank_t b_nxt;
  logic [WIDTH-1:0] set;

  // no enable, no set, whatever the line does
  assign set = (rise & rise_en) | (fall & fall_en);

  always_comb begin
    b_nxt = b_r;
    // set beats clear so a coincident edge survives
    b_nxt.flags = (b_r.flags & ~clr) | set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_r.flags <= STATUS_RESET[WIDTH-1:0];
    end else begin
      b_r <= b_nxt;
    end
  end

  assign flags = b_r.flags;

endmodule // edge_flag_bank

// ===== logic/line_edge_sampler.sv
module line_edge_sampler #(
  parameter int WIDTH = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] line_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  import dio_edge_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
    logic [1:0] settle;
  } sampler_t;

  sampler_t s_r;
  sampler_t s_nxt;
  logic armed;

  // history is garbage until the pipe fills; avoids a fake edge at reset
  assign armed = (s_r.settle == SETTLE_CYCLES);

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = line_in;
    s_nxt.stable = s_r.meta;
    s_nxt.prev = s_r.stable;
    if (!armed) begin
      s_nxt.settle = s_r.settle + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.stable;
  assign rise = armed ? (s_r.stable & ~s_r.prev) : '0;
  assign fall = armed ? (~s_r.stable & s_r.prev) : '0;

endmodule // line_edge_sampler
